// [hdl/mbs_pkg.sv]
// shared constants and types of the memory bus cycle sequencer
package mbs_pkg;

    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam int CNT_W  = 9;

    // word stepping and boundaries
    localparam logic [ADDR_W-1:0] WORD_STEP = 32'h0000_0004;
    localparam logic [ADDR_W-1:0] LINE_MASK = 32'hffff_ffe0;
    localparam logic [CNT_W-1:0]  LINE_WORDS = 9'h008;
    localparam logic [CNT_W-1:0]  CNT_ONE    = 9'h001;
    localparam int                SEQ_LSB    = 2;
    localparam int                SEQ_MSB    = 9;

    // idle cycles of an aborted swap write phase
    localparam logic [1:0] ABORT_IDLES = 2'h3;
    localparam logic [1:0] IDLE_ONE    = 2'h1;

    typedef enum logic [2:0] {
        MBS_UNCACHED_READ    = 3'h0,
        MBS_UNBUF_WRITE      = 3'h1,
        MBS_BUF_WRITE        = 3'h2,
        MBS_LINEFETCH        = 3'h3,
        MBS_SWAP_INSTRUCTION = 3'h4
    } mbs_kind_t;

    typedef enum logic [1:0] {
        WALK_NONE    = 2'h0,
        WALK_SECTION = 2'h1,
        WALK_PAGE    = 2'h2
    } mbs_walk_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_MEM   = 4'b0100,
        ST_ABORT = 4'b1000
    } mbs_state_t;

    typedef enum logic [3:0] {
        PH_L1   = 4'b0001,
        PH_L2   = 4'b0010,
        PH_MAIN = 4'b0100,
        PH_SWPW = 4'b1000
    } mbs_phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr;
        logic              word;
        logic [CNT_W-1:0]  cnt;
    } mbs_acc_t;

endpackage

// [hdl/mbs_sequencer.sv]
// memory bus cycle sequencer: core request side and bus clock side
// How it works
// R1: a level-two table fetch is always preceded by a level-one fetch
// R2: section mapping needs one fetch, page mapping adds a level-two fetch
// R3: every table fetch goes out as a word read
// R4: swap reads then writes the same address, each non-sequential
// R5: lock rises with address timing at start of the swap read
// R6: lock falls at the end of the swap write access
// R7: swap read is always one non-sequential external read
// R8: swap write is unbuffered so it can abort; cache updates on it
// R9: the controller changes stall only in the low bus clock phase
// R10: stall low stretches the access by whole bus clock cycles
// R11: request, sequential and data freeze once stall is low
// R12: all other outputs freeze until a high phase after stall release
// R13: address and control follow a released latch strobe despite stall
// R14: single access: start, repeats, closing idle holding old address
// R15: buffered write: start plus as many repeats as needed
// R16: swap: read phase then one unbuffered or aborted write phase
// R17: memory request is pipelined and announces the following cycle
// R18: non-sequential access is an address idle cycle then memory cycle
// R19: idle cycles keep address, direction and size unchanged
// R20: linefetch is eight word reads from an eight-word boundary
// R21: lock stays high across idles between swap read and write
// R22: sequences go out whole, back to back, never interleaved
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer (
    input  wire logic                       clock_i,
    input  wire logic                       rst_i,
    input  wire logic                       bus_clk_i,
    input  wire logic                       req_valid_i,
    input  wire mbs_pkg::mbs_kind_t         req_kind_i,
    input  wire mbs_pkg::mbs_walk_t         req_walk_i,
    input  wire logic [mbs_pkg::ADDR_W-1:0] req_l1_addr_i,
    input  wire logic [mbs_pkg::ADDR_W-1:0] req_l2_addr_i,
    input  wire logic [mbs_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [mbs_pkg::CNT_W-1:0]  req_words_i,
    input  wire logic                       req_byte_i,
    input  wire logic [mbs_pkg::DATA_W-1:0] req_wdata_i,
    input  wire logic                       req_abort_i,
    output logic                            req_ready_o,
    output logic                            done_o,
    output logic [mbs_pkg::DATA_W-1:0]      rdata_o,
    input  wire logic                       stall_request_n_i,
    input  wire logic                       ale_i,
    input  wire logic [mbs_pkg::DATA_W-1:0] data_i,
    output logic [mbs_pkg::ADDR_W-1:0]      addr_o,
    output logic                            write_not_read_o,
    output logic                            word_not_byte_o,
    output logic                            memory_request_n_o,
    output logic                            follow_on_cycle_o,
    output logic                            lock_o,
    output logic [mbs_pkg::DATA_W-1:0]      data_o,
    output logic                            data_oe_o
);
    import mbs_pkg::*;

    typedef struct packed {
        logic              busy;
        logic              ready;
        logic              done;
        logic              req_tgl;
        logic              ack_seen;
        mbs_kind_t         kind;
        mbs_walk_t         walk;
        logic [ADDR_W-1:0] l1;
        logic [ADDR_W-1:0] l2;
        logic [ADDR_W-1:0] addr;
        logic [CNT_W-1:0]  words;
        logic              byte_acc;
        logic [DATA_W-1:0] wdata;
        logic              abort;
        logic [DATA_W-1:0] rdata;
    } mbs_core_t;

    typedef struct packed {
        mbs_state_t        st;
        mbs_phase_t        ph;
        logic              req_seen;
        logic              ack_tgl;
        mbs_kind_t         kind;
        mbs_walk_t         walk;
        logic [ADDR_W-1:0] l1;
        logic [ADDR_W-1:0] l2;
        logic [ADDR_W-1:0] base;
        logic [ADDR_W-1:0] cur;
        logic [CNT_W-1:0]  words;
        logic [CNT_W-1:0]  cnt;
        logic              byte_acc;
        logic [DATA_W-1:0] wdata;
        logic              abort;
        logic [1:0]        idles;
        logic              ale_hold;
        logic [ADDR_W-1:0] addr;
        logic              wr;
        logic              word;
        logic              memory_request_n;
        logic              seq;
        logic              lock;
        logic [DATA_W-1:0] dout;
        logic              doe;
        logic [DATA_W-1:0] rdata;
    } mbs_bus_t;

    mbs_core_t c_r;
    mbs_core_t c_nxt;
    mbs_bus_t  b_r;
    mbs_bus_t  b_nxt;
    mbs_bus_t  adv;
    logic      b_rst;
    logic      req_q;
    logic      ack_q;

    mbs_sync_if req_x ();
    mbs_sync_if ack_x ();
    mbs_sync_if rst_x ();

    // crossings: request toggle, done toggle and reset
    assign req_x.in_lvl = c_r.req_tgl;
    assign ack_x.in_lvl = b_r.ack_tgl;
    assign rst_x.in_lvl = rst_i;
    assign req_q        = req_x.out_lvl;
    assign ack_q        = ack_x.out_lvl;
    assign b_rst        = rst_x.out_lvl;

    mbs_sync u_rst_sync (
        .clock_i (bus_clk_i),
        .rst_i   (1'b0),
        .port    (rst_x)
    );

    mbs_sync u_req_sync (
        .clock_i (bus_clk_i),
        .rst_i   (b_rst),
        .port    (req_x)
    );

    mbs_sync u_ack_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .port    (ack_x)
    );

    // shape of one access of a phase
    function automatic mbs_acc_t plan(mbs_bus_t s, mbs_phase_t ph);
        mbs_acc_t a;
        a.addr = s.base;
        a.wr   = 1'b0;
        a.word = !s.byte_acc;
        a.cnt  = CNT_ONE;
        unique case (ph)
            PH_L1: begin
                a.addr = s.l1;
                a.word = 1'b1; // R3
            end
            PH_L2: begin
                a.addr = s.l2;
                a.word = 1'b1; // R3
            end
            PH_MAIN: begin
                if (s.kind == MBS_LINEFETCH) begin
                    a.addr = s.base & LINE_MASK; // R20
                    a.word = 1'b1;
                    a.cnt  = LINE_WORDS;
                end else if (s.kind != MBS_SWAP_INSTRUCTION) begin // R7
                    a.wr  = (s.kind != MBS_UNCACHED_READ); // R15
                    a.cnt = s.words;
                end
            end
            PH_SWPW: a.wr = 1'b1; // R8
            default: a.cnt = CNT_ONE;
        endcase
        return a;
    endfunction

    // sequential run broken at a sub-page boundary
    function automatic logic brk(logic [ADDR_W-1:0] a);
        return (a[SEQ_MSB:SEQ_LSB] == '0);
    endfunction

    // idle cycle carrying the first address of an access
    function automatic mbs_bus_t enter(mbs_bus_t s, mbs_phase_t ph);
        mbs_bus_t r;
        mbs_acc_t a;
        r       = s;
        a       = plan(s, ph);
        r.ph    = ph;
        r.st    = ST_ADDR; // R18
        r.addr  = a.addr;
        r.cur   = a.addr;
        r.cnt   = a.cnt;
        r.wr    = a.wr;
        r.word  = a.word;
        r.memory_request_n = 1'b0; // R17
        r.doe   = 1'b0;
        if (s.kind == MBS_SWAP_INSTRUCTION && ph != PH_L1 && ph != PH_L2) begin
            r.lock = 1'b1; // R5
        end
        return r;
    endfunction

    // memory cycle with the next address pipelined
    function automatic mbs_bus_t mem_cycle(mbs_bus_t s);
        mbs_bus_t          r;
        logic [ADDR_W-1:0] n;
        r    = s;
        n    = s.cur + WORD_STEP;
        r.st = ST_MEM;
        if (s.cnt > CNT_ONE && !brk(n)) begin
            r.addr  = n;
            r.memory_request_n = 1'b0; // R17
        end else begin
            r.memory_request_n = 1'b1;
        end
        r.doe  = s.wr;
        r.dout = s.wdata;
        return r;
    endfunction

    // closing idle cycle keeps address and direction
    function automatic mbs_bus_t finish(mbs_bus_t s);
        mbs_bus_t r;
        r         = s;
        r.st      = ST_IDLE; // R14 R19
        r.memory_request_n   = 1'b1;
        r.doe     = 1'b0;
        r.lock    = 1'b0; // R6
        r.ack_tgl = !s.ack_tgl;
        return r;
    endfunction

    // bus side: one step per bus clock cycle
    always_comb begin
        adv = b_r;
        unique case (b_r.st)
            ST_IDLE: begin
                adv.memory_request_n = 1'b1;
                if (req_q != b_r.req_seen) begin // R22
                    adv.req_seen = req_q;
                    adv.kind     = c_r.kind;
                    adv.walk     = c_r.walk;
                    adv.l1       = c_r.l1;
                    adv.l2       = c_r.l2;
                    adv.base     = c_r.addr;
                    adv.words    = c_r.words;
                    adv.byte_acc = c_r.byte_acc;
                    adv.wdata    = c_r.wdata;
                    adv.abort    = c_r.abort;
                    adv = enter(adv, (c_r.walk == WALK_NONE) ? PH_MAIN : PH_L1); // R2
                end
            end
            ST_ADDR: adv = mem_cycle(b_r);
            ST_MEM: begin
                if (!b_r.wr) begin
                    adv.rdata = data_i;
                end
                adv.cnt = b_r.cnt - CNT_ONE;
                adv.cur = b_r.cur + WORD_STEP;
                if (b_r.cnt > CNT_ONE) begin
                    if (brk(adv.cur)) begin
                        adv.st    = ST_ADDR;
                        adv.addr  = adv.cur;
                        adv.memory_request_n = 1'b0;
                        adv.doe   = 1'b0;
                    end else begin
                        adv = mem_cycle(adv); // R14 R15 R20
                    end
                end else if (b_r.ph == PH_L1) begin
                    adv = enter(adv, (b_r.walk == WALK_PAGE) ? PH_L2 : PH_MAIN); // R1 R2
                end else if (b_r.ph == PH_L2) begin
                    adv = enter(adv, PH_MAIN); // R1
                end else if (b_r.ph == PH_MAIN && b_r.kind == MBS_SWAP_INSTRUCTION) begin
                    if (b_r.abort) begin
                        adv.st    = ST_ABORT; // R16
                        adv.ph    = PH_SWPW;
                        adv.idles = ABORT_IDLES;
                        adv.wr    = 1'b0;
                        adv.memory_request_n = 1'b1;
                        adv.doe   = 1'b0;
                        adv.addr  = b_r.base;
                    end else begin
                        adv = enter(adv, PH_SWPW); // R4 R16 R21
                    end
                end else begin
                    adv = finish(adv);
                end
            end
            ST_ABORT: begin
                if (b_r.idles == IDLE_ONE) begin
                    adv = finish(adv); // R6
                end else begin
                    adv.idles = b_r.idles - IDLE_ONE;
                end
            end
            default: adv = finish(b_r);
        endcase

        // stall holds the cycle; a released latch strobe still moves address
        if (!stall_request_n_i) begin // R10 R11 R12
            b_nxt = b_r;
            if (!ale_i) begin
                b_nxt.ale_hold = 1'b1;
            end else if (b_r.ale_hold) begin
                b_nxt.addr     = adv.addr; // R13
                b_nxt.wr       = adv.wr;
                b_nxt.word     = adv.word;
                b_nxt.lock     = adv.lock;
                b_nxt.ale_hold = 1'b0;
            end
        end else begin
            b_nxt          = adv;
            b_nxt.ale_hold = 1'b0;
        end
        b_nxt.seq = !b_nxt.memory_request_n;

        if (b_rst) begin
            b_nxt       = '0;
            b_nxt.st    = ST_IDLE;
            b_nxt.ph    = PH_MAIN;
            b_nxt.kind  = MBS_UNCACHED_READ;
            b_nxt.walk  = WALK_NONE;
            b_nxt.word  = 1'b1;
            b_nxt.memory_request_n = 1'b1;
        end
    end

    always_ff @(posedge bus_clk_i) begin
        b_r <= b_nxt;
    end

    // core side: take a request, wait for its completion
    always_comb begin
        c_nxt      = c_r;
        c_nxt.done = 1'b0;
        if (c_r.busy) begin
            if (ack_q != c_r.ack_seen) begin
                c_nxt.ack_seen = ack_q;
                c_nxt.busy     = 1'b0;
                c_nxt.done     = 1'b1;
                c_nxt.rdata    = b_r.rdata;
            end
        end else if (req_valid_i) begin
            c_nxt.busy     = 1'b1;
            c_nxt.req_tgl  = !c_r.req_tgl;
            c_nxt.kind     = req_kind_i;
            c_nxt.walk     = req_walk_i;
            c_nxt.l1       = req_l1_addr_i;
            c_nxt.l2       = req_l2_addr_i;
            c_nxt.addr     = req_addr_i;
            c_nxt.words    = req_words_i;
            c_nxt.byte_acc = req_byte_i;
            c_nxt.wdata    = req_wdata_i;
            c_nxt.abort    = req_abort_i;
        end
        c_nxt.ready = !c_nxt.busy;
        if (rst_i) begin
            c_nxt      = '0;
            c_nxt.kind = MBS_UNCACHED_READ;
            c_nxt.walk = WALK_NONE;
        end
    end

    always_ff @(posedge clock_i) begin
        c_r <= c_nxt;
    end

    // outputs straight from state flops
    assign req_ready_o        = c_r.ready;
    assign done_o             = c_r.done;
    assign rdata_o            = c_r.rdata;
    assign addr_o             = b_r.addr;
    assign write_not_read_o   = b_r.wr;
    assign word_not_byte_o    = b_r.word;
    assign memory_request_n_o = b_r.memory_request_n;
    assign follow_on_cycle_o  = b_r.seq;
    assign lock_o             = b_r.lock;
    assign data_o             = b_r.dout;
    assign data_oe_o          = b_r.doe;

    // checks on the bus side
    trans_word_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R3
        (b_r.st == ST_ADDR && (b_r.ph == PH_L1 || b_r.ph == PH_L2))
        |-> (!write_not_read_o && word_not_byte_o))
        else $error("table fetch not a word read");
    l2_order_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R1
        (b_r.ph == PH_L2 && $changed(b_r.ph)) |-> ($past(b_r.ph) == PH_L1))
        else $error("level two fetch without level one");
    walk_page_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R2
        (b_r.st == ST_ADDR && b_r.ph == PH_L2) |-> (b_r.walk == WALK_PAGE))
        else $error("level two fetch for a section");
    swap_addr_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R4
        (b_r.st == ST_ADDR && b_r.ph == PH_SWPW && $changed(b_r.ph))
        |-> (addr_o == b_r.base && write_not_read_o && $past(memory_request_n_o)))
        else $error("swap write not to read address");
    lock_rise_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R5
        $rose(lock_o) |-> (b_r.st == ST_ADDR && b_r.ph == PH_MAIN && !write_not_read_o))
        else $error("lock rose outside swap read start");
    lock_fall_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R6
        $fell(lock_o) |-> (b_r.st == ST_IDLE && $past(b_r.st) != ST_ADDR))
        else $error("lock fell before write end");
    lock_gap_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R21
        (b_r.ph == PH_SWPW && b_r.st != ST_IDLE) |-> lock_o)
        else $error("lock dropped inside swap");
    stall_hold_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R11
        !stall_request_n_i |=> ($stable(memory_request_n_o) && $stable(data_o)
        && $stable(data_oe_o) && $stable(follow_on_cycle_o)))
        else $error("request or data moved in stall");
    stall_addr_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R12
        (!stall_request_n_i && !(b_r.ale_hold && ale_i))
        |=> ($stable(addr_o) && $stable(lock_o) && $stable(write_not_read_o)))
        else $error("address moved in stall");
    ale_move_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R13
        (!stall_request_n_i && b_r.ale_hold && ale_i) |=> !b_r.ale_hold)
        else $error("latch release not taken");
    line_start_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R20
        (b_r.st == ST_ADDR && b_r.ph == PH_MAIN && b_r.kind == MBS_LINEFETCH)
        |-> (addr_o[4:0] == 5'h00 && b_r.cnt == LINE_WORDS && !write_not_read_o))
        else $error("linefetch misaligned");
    idle_keep_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R19
        (b_r.st == ST_IDLE && req_q == b_r.req_seen)
        |=> ($stable(addr_o) && $stable(write_not_read_o) && $stable(word_not_byte_o)))
        else $error("idle changed address");
    abort_idle_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R16
        (b_r.st == ST_ABORT) |-> (memory_request_n_o && !write_not_read_o && !data_oe_o))
        else $error("aborted swap not idle read");
    seq_inv_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R17
        follow_on_cycle_o == !memory_request_n_o)
        else $error("sequential flag not inverse");
    one_seq_a: assert property (@(posedge bus_clk_i) disable iff (b_rst || rst_i) // R22
        $changed(b_r.req_seen) |-> ($past(b_r.st) == ST_IDLE))
        else $error("sequence started mid sequence");
endmodule
`default_nettype wire

// [hdl/mbs_sync.sv]
// two flip-flop level synchroniser
`timescale 1ns/10ps
`default_nettype none
module mbs_sync (
    input  wire logic clock_i,
    input  wire logic rst_i,
    mbs_sync_if.sync  port
);
    typedef struct packed {
        logic meta;
        logic hold;
    } mbs_sync_st_t;

    mbs_sync_st_t s_r;
    mbs_sync_st_t s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt.meta = port.in_lvl;
        s_nxt.hold = s_r.meta;
        if (rst_i) begin
            s_nxt = '0;
        end
    end

    always_ff @(posedge clock_i) begin
        s_r <= s_nxt;
    end

    assign port.out_lvl = s_r.hold;
endmodule
`default_nettype wire

// [hdl/mbs_sync_if.sv]
// level carried across a clock boundary
`timescale 1ns/10ps
`default_nettype none
interface mbs_sync_if;
    logic in_lvl;
    logic out_lvl;
    modport sync (input in_lvl, output out_lvl);
    modport user (output in_lvl, input out_lvl);
endinterface
`default_nettype wire

// [testbench/mbs_mem_model.sv]
// memory controller model: read data and stall injection
`timescale 1ns/10ps
`default_nettype none
module mbs_mem_model (
    input  wire logic        bus_clk_i,
    input  wire logic        stall_en_i,
    input  wire logic [31:0] addr_i,
    input  wire logic        mreq_n_i,
    input  wire logic        wnr_i,
    output logic             stall_n_o,
    output logic             ale_o,
    output logic [31:0]      data_o
);
    logic in_mem;
    initial begin
        stall_n_o = 1'b1;
        ale_o = 1'b1;
        data_o = 32'h0;
        in_mem = 1'b0;
    end
    // read data for the coming memory cycle, else a changing pattern
    always @(posedge bus_clk_i) begin
        if (stall_n_o) begin
            in_mem <= !mreq_n_i;
            if (!mreq_n_i && !wnr_i)
                data_o <= addr_i ^ 32'ha5a5_a5a5;
            else
                data_o <= ~data_o;
        end
    end
    // stall moves in the low phase only, two cycles per memory cycle;
    // latch strobe low in the first, back high in the second
    always @(negedge bus_clk_i) begin
        if (stall_n_o) begin
            stall_n_o <= !(stall_en_i && in_mem);
            ale_o     <= !(stall_en_i && in_mem);
        end else begin
            stall_n_o <= ale_o;
            ale_o     <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// [testbench/mbs_sequencer_bench.sv]
// self-checking bench of the memory bus cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module mbs_sequencer_bench;
    import mbs_pkg::*;
    logic        clock_i, rst_i, bus_clk, req_valid, req_byte, req_abort, stall_en;
    mbs_kind_t   req_kind;
    mbs_walk_t   req_walk;
    logic [31:0] req_addr, req_wdata, rdata, addr_o, data_o, data_i, first_a, last_a;
    logic [8:0]  req_words;
    logic        ready, done, wnr, wnb, mreq_n, follow, lock, oe, stall_n, ale, pend_wr;
    int          mismatches, samples_checked, cycles, mem_cnt, wr_cnt, lock_cnt, byte_cnt;

    mbs_sequencer mbs_sequencer_i (.clock_i(clock_i), .rst_i(rst_i), .bus_clk_i(bus_clk),
        .req_valid_i(req_valid), .req_kind_i(req_kind), .req_walk_i(req_walk),
        .req_l1_addr_i(32'h0000_8000), .req_l2_addr_i(32'h0000_9000),
        .req_addr_i(req_addr), .req_words_i(req_words), .req_byte_i(req_byte),
        .req_wdata_i(req_wdata), .req_abort_i(req_abort), .req_ready_o(ready),
        .done_o(done), .rdata_o(rdata), .stall_request_n_i(stall_n), .ale_i(ale),
        .data_i(data_i), .addr_o(addr_o), .write_not_read_o(wnr), .word_not_byte_o(wnb),
        .memory_request_n_o(mreq_n), .follow_on_cycle_o(follow), .lock_o(lock),
        .data_o(data_o), .data_oe_o(oe));
    mbs_mem_model mbs_mem_model_i (.bus_clk_i(bus_clk), .stall_en_i(stall_en),
        .addr_i(addr_o), .mreq_n_i(mreq_n), .wnr_i(wnr), .stall_n_o(stall_n),
        .ale_o(ale), .data_o(data_i));

    // clocks: core 25 ns, bus 32 ns with an unrelated phase
    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end
    initial begin
        bus_clk = 1'b0;
        #7;
        forever #16 bus_clk = ~bus_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // bus monitor: memory cycles, writes, lock and write data
    always @(posedge bus_clk) begin
        if (!rst_i && stall_n) begin
            if (pend_wr)
                check(data_o, req_wdata);
            check({31'h0, oe}, {31'h0, pend_wr});
            check({31'h0, follow}, {31'h0, ~mreq_n});
            pend_wr = !mreq_n && wnr;
            if (!mreq_n) begin
                if (mem_cnt == 0)
                    first_a = addr_o;
                last_a = addr_o;
                mem_cnt++;
                wr_cnt += int'(wnr);
                lock_cnt += int'(lock);
                byte_cnt += int'(!wnb);
            end
        end
    end

    // one request, waited on under a bound
    task automatic run(input mbs_kind_t k, input mbs_walk_t w, input logic [31:0] a,
                       input logic [8:0] n, input logic b, input logic ab);
        int t;
        mem_cnt = 0;
        wr_cnt = 0;
        lock_cnt = 0;
        byte_cnt = 0;
        @(negedge clock_i);
        req_kind = k;
        req_walk = w;
        {req_addr, req_words, req_byte, req_abort} = {a, n, b, ab};
        req_wdata = a ^ 32'h1111_0000;
        req_valid = 1'b1;
        @(negedge clock_i);
        req_valid = 1'b0;
        check({31'h0, ready}, 32'h0);
        t = 0;
        while (done !== 1'b1 && t < 4000) begin
            @(negedge clock_i);
            t++;
        end
        if (t == 4000)
            check(32'h0, 32'h1);
        check({31'h0, ready}, 32'h1);
        repeat (8) @(negedge clock_i);
    endtask

    task automatic t_single();
        run(MBS_UNCACHED_READ, WALK_NONE, 32'h100, 9'h001, 1'b0, 1'b0);
        check(mem_cnt, 1);
        check(rdata, 32'h100 ^ 32'ha5a5_a5a5);
        run(MBS_UNBUF_WRITE, WALK_NONE, 32'h200, 9'h003, 1'b0, 1'b0);
        check(wr_cnt, 3);
        check(last_a, 32'h208);
        run(MBS_BUF_WRITE, WALK_NONE, 32'h300, 9'h002, 1'b0, 1'b0);
        check(wr_cnt, 2);
        $display("single and buffered accesses done");
    endtask

    task automatic t_line();
        run(MBS_LINEFETCH, WALK_NONE, 32'h1234, 9'h001, 1'b1, 1'b0);
        check(mem_cnt, 8);
        check(first_a, 32'h1220);
        check(last_a, 32'h123c);
        check(byte_cnt, 0);
        check(rdata, 32'h123c ^ 32'ha5a5_a5a5);
        $display("linefetch done");
    endtask

    task automatic t_walk();
        run(MBS_UNBUF_WRITE, WALK_PAGE, 32'h400, 9'h001, 1'b1, 1'b0);
        check(mem_cnt, 3);
        check(wr_cnt, 1);
        check(byte_cnt, 1);
        check(first_a, 32'h8000);
        run(MBS_UNCACHED_READ, WALK_SECTION, 32'h480, 9'h001, 1'b0, 1'b0);
        check(mem_cnt, 2);
        check(first_a, 32'h8000);
        $display("table fetches done");
    endtask

    task automatic t_swap();
        run(MBS_SWAP_INSTRUCTION, WALK_NONE, 32'h500, 9'h001, 1'b0, 1'b0);
        check(mem_cnt, 2);
        check(wr_cnt, 1);
        check(lock_cnt, 2);
        check(last_a, 32'h500);
        check({31'h0, lock}, 32'h0);
        run(MBS_SWAP_INSTRUCTION, WALK_NONE, 32'h540, 9'h001, 1'b0, 1'b1);
        check(mem_cnt, 1);
        check(wr_cnt, 0);
        check(lock_cnt, 1);
        check({31'h0, lock}, 32'h0);
        $display("swap done");
    endtask

    task automatic t_stall();
        stall_en = 1'b1;
        run(MBS_UNCACHED_READ, WALK_NONE, 32'h600, 9'h002, 1'b0, 1'b0);
        check(mem_cnt, 2);
        check(rdata, 32'h604 ^ 32'ha5a5_a5a5);
        run(MBS_UNBUF_WRITE, WALK_NONE, 32'h700, 9'h002, 1'b0, 1'b0);
        check(wr_cnt, 2);
        stall_en = 1'b0;
        $display("stalled accesses done");
    endtask

    // cut a hang short
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end

    // main sequence
    initial begin
        {mismatches, samples_checked, cycles} = '0;
        {req_valid, req_byte, req_abort, stall_en, pend_wr} = '0;
        req_kind = MBS_UNCACHED_READ;
        req_walk = WALK_NONE;
        {req_addr, req_words, req_wdata} = '0;
        rst_i = 1'b1;
        repeat (8) @(negedge clock_i);
        rst_i = 1'b0;
        repeat (6) @(negedge clock_i);
        t_single();
        t_line();
        t_walk();
        t_swap();
        t_stall();
        print_verdict();
    end
endmodule
`default_nettype wire
